// ### hw/pmc_pad_decode.sv
// Decode of one pin's configuration into pad control levels.
// Assumes the caller registers the result.
`timescale 1ns/1ns
`include "pmc_params.svh"
module pmc_pad_decode (
    // Configuration
    input wire pmc_pkg::pmc_cfg_s cfg,
    input wire logic analogMode,
    // Pad controls
    output pmc_pkg::pmc_pad_s pad
);
    import pmc_pkg::*;

    // Analog mode masks the direction/pull field entirely
    always_comb begin
        pad.functionSelect = cfg.functionSelect;
        pad.openDrain = 1'b0;
        pad.outputEnable = 1'b0;
        pad.pullUpEn = 1'b0;
        pad.pullDownEn = 1'b0;
        if (!analogMode) begin
            pad.outputEnable =
                (cfg.directionPullSelect == `PMC_CODE_OUTPUT);
            pad.openDrain = pad.outputEnable & cfg.driveTypeSelect;
            pad.pullUpEn =
                (cfg.directionPullSelect == `PMC_CODE_PULLUP);
            pad.pullDownEn =
                (cfg.directionPullSelect == `PMC_CODE_PULLDN);
        end
    end
endmodule

// ### hw/pmc_pad_mode_config.sv
// Pad mode configuration registers for five port-1 pins, on APB.
// Each pin has one word: drive type, direction/pull and function select.
// Assumes synchronous APB master on sys_clk, pads outside take the controls.
// Assumes analogMode comes from the converter mux, already on sys_clk.
`timescale 1ns/1ns
`include "pmc_params.svh"
module pmc_pad_mode_config (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog mode per pin
    input wire logic [4:0] analogMode,
    // Pad controls per pin
    output pmc_pkg::pmc_pad_s [4:0] padCtrl
);
    import pmc_pkg::*;

    // ****************************************
    // Address decode
    // ****************************************
    // Returns the pin index, or 7 when nothing matches
    function automatic logic [2:0] pinIndex(input logic [31:0] a);
        logic [2:0] idx;
        idx = 3'h7;
        if (a == `PMC_OFS_PIN08) idx = 3'h0;
        else if (a == `PMC_OFS_PIN09) idx = 3'h1;
        else if (a == `PMC_OFS_PIN10) idx = 3'h2;
        else if (a == `PMC_OFS_PIN11) idx = 3'h3;
        else if (a == `PMC_OFS_PIN12) idx = 3'h4;
        return idx;
    endfunction

    // Places one pin's fields at their word positions; every other bit,
    // reserved 7:6 included, reads as zero
    function automatic logic [31:0] packCfg(input pmc_cfg_s c);
        logic [31:0] w;
        w = 32'h0;
        w[`PMC_DRIVE_BIT] = c.driveTypeSelect;
        w[`PMC_DIRPULL_HI:`PMC_DIRPULL_LO] = c.directionPullSelect;
        w[`PMC_FUNC_HI:`PMC_FUNC_LO] = c.functionSelect;
        return w;
    endfunction

    pmc_cfg_s cfg [0:4];
    pmc_pad_s nextPad [0:4];
    logic [2:0] selIdx;
    logic hit;
    logic setupPhase;
    logic wrStrobe;

    assign selIdx = pinIndex(paddr);
    assign hit = (selIdx != 3'h7);
    // Answer in the first access cycle; zero wait states
    assign setupPhase = psel & ~penable;
    // Access edge of a mapped write; pready marks the one access edge,
    // so a held request can never store twice
    assign wrStrobe = psel & penable & pready & pwrite & hit;

    // ****************************************
    // Register storage
    // ****************************************
    // Writes land at the access edge; reserved bits are never stored
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `PMC_PIN_COUNT; i++) begin
                cfg[i].driveTypeSelect <= `PMC_DRIVE_RST;
                cfg[i].directionPullSelect <= `PMC_DIRPULL_RST;
                cfg[i].functionSelect <= `PMC_FUNC_RST;
            end
        end else if (clkEn && wrStrobe) begin
            cfg[selIdx].driveTypeSelect <= pwdata[`PMC_DRIVE_BIT];
            cfg[selIdx].directionPullSelect <=
                pwdata[`PMC_DIRPULL_HI:`PMC_DIRPULL_LO];
            cfg[selIdx].functionSelect <=
                pwdata[`PMC_FUNC_HI:`PMC_FUNC_LO];
        end
    end

    // ****************************************
    // Bus answer
    // ****************************************
    // Ready and read data are prepared in the setup cycle so they come
    // straight from flops during the access cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (clkEn) begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~hit;
            prdata <= 32'h0;
            if (setupPhase && hit && !pwrite) begin
                // Bits 7:6 and 31:11 read as zero
                prdata <= packCfg(cfg[selIdx]);
            end
        end
    end

    // ****************************************
    // Pad control outputs
    // ****************************************
    for (genvar g = 0; g < `PMC_PIN_COUNT; g++) begin : gPin
        pmc_pad_decode uDecode (
            .cfg(cfg[g]),
            .analogMode(analogMode[g]),
            .pad(nextPad[g])
        );
    end

    // Registered so pads never see decode glitches
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `PMC_PIN_COUNT; i++) begin
                padCtrl[i] <= '{1'b0, 1'b0, 1'b0, 1'b1, 6'h00};
            end
        end else if (clkEn) begin
            for (int i = 0; i < `PMC_PIN_COUNT; i++) begin
                padCtrl[i] <= nextPad[i];
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_OUT_DRIVE: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && !analogMode[0] && cfg[0].directionPullSelect == 2'h3
        |=> padCtrl[0].outputEnable
            && padCtrl[0].openDrain == $past(cfg[0].driveTypeSelect))
        else $error("pin drive type not applied");
    AST_INPUT_DIR: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && cfg[1].directionPullSelect != 2'h3
        |=> !padCtrl[1].outputEnable && !padCtrl[1].openDrain)
        else $error("input pin is driving");
    AST_PULL_UP: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && !analogMode[2] && cfg[2].directionPullSelect == 2'h1
        |=> padCtrl[2].pullUpEn && !padCtrl[2].pullDownEn)
        else $error("pull-up not applied");
    AST_PULL_DOWN: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && !analogMode[3] && cfg[3].directionPullSelect == 2'h2
        |=> padCtrl[3].pullDownEn && !padCtrl[3].pullUpEn)
        else $error("pull-down not applied");
    AST_RESET_VAL: assert property (@(posedge sys_clk)
        $fell(rst) |-> cfg[4].directionPullSelect == 2'h2)
        else $error("direction/pull reset value wrong");
    AST_ANALOG: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && analogMode[4] |=> !padCtrl[4].outputEnable
            && !padCtrl[4].pullUpEn && !padCtrl[4].pullDownEn)
        else $error("analog pin still uses direction/pull");
    AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        pready |-> prdata[7:6] == 2'h0 && prdata[31:11] == 21'h0)
        else $error("reserved bits not zero");
    AST_WRITE_FUNC: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && psel && penable && pready && pwrite
            && paddr == `PMC_OFS_PIN08
        |=> cfg[0].functionSelect == $past(pwdata[5:0]))
        else $error("function select not written");
    AST_ONE_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && psel && !penable |=> pready)
        else $error("access not answered in one cycle");

    // ****************************************
    // Bus answer checks
    // ****************************************
    // Ready is a one-cycle pulse; holding it would let a master that
    // starts its next setup at once see a stale answer
    AST_READY_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && pready |=> !pready)
        else $error("ready held past one access cycle");
    // Off-map addresses are refused with zero data
    AST_UNMAPPED_ERR: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && psel && !penable && !hit
        |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && psel && !penable && hit |=> !pslverr)
        else $error("mapped access flagged as error");
    // Read word of pin 08 is its stored fields, reserved bits zero
    AST_READ_PIN08: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && psel && !penable && !pwrite && paddr == `PMC_OFS_PIN08
        |=> prdata == $past(packCfg(cfg[0])))
        else $error("pin 08 read data wrong");

    // ****************************************
    // Register write checks
    // ****************************************
    AST_WR_DRIVE: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && psel && penable && pready && pwrite
            && paddr == `PMC_OFS_PIN08
        |=> cfg[0].driveTypeSelect == $past(pwdata[`PMC_DRIVE_BIT]))
        else $error("drive type not written");
    AST_WR_DIRPULL: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && psel && penable && pready && pwrite
            && paddr == `PMC_OFS_PIN08
        |=> cfg[0].directionPullSelect
            == $past(pwdata[`PMC_DIRPULL_HI:`PMC_DIRPULL_LO]))
        else $error("direction/pull not written");
    // A write elsewhere, mapped or not, must leave pin 08 alone
    AST_WR_ISOLATE: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && psel && penable && pready && pwrite
            && paddr != `PMC_OFS_PIN08
        |=> $stable(cfg[0]))
        else $error("write to another address changed pin 08");

    // ****************************************
    // Pad output checks
    // ****************************************
    // The function selector passes to the pad untouched, analog or not
    AST_PAD_FUNC: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn |=> padCtrl[0].functionSelect == $past(cfg[0].functionSelect))
        else $error("function select not passed to pad");
    // Open drain without an output would leave a pad half configured
    for (genvar g = 0; g < `PMC_PIN_COUNT; g++) begin : gOdCheck
        AST_OD_OUTPUT: assert property (@(posedge sys_clk)
            padCtrl[g].openDrain |-> padCtrl[g].outputEnable)
            else $error("open drain shown on a non-output pin");
    end
    // Clock enable low must hold the pad controls, pready and pin 08's register where they stand
    AST_FROZEN: assert property (@(posedge sys_clk) disable iff (rst)
        !clkEn |=> $stable(padCtrl) && $stable(pready) && $stable(cfg[0]))
        else $error("state moved with clock enable low");
    // Out of reset pin 08 is a pulled-down input even if it was an output
    AST_RESET_PAD: assert property (@(posedge sys_clk)
        $fell(rst) |-> cfg[0].directionPullSelect == `PMC_DIRPULL_RST
            && padCtrl[0].pullDownEn && !padCtrl[0].outputEnable)
        else $error("pin 08 not a pulled-down input after reset");
endmodule

// ### hw/pmc_params.svh
// Constants of the pad mode configuration block: offsets, fields, resets.
// Assumes a 32-bit APB slave decoding full byte addresses.
// Contract
// - Drive bit 0 push-pull, 1 open drain
// - Field 11 makes output, no pulls
// - Input pulls: 00 none, 01 up, 10 down
// - Direction/pull field resets to 0x2
// - Analog mode ignores direction/pull field
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define PMC_PIN_COUNT 5
`define PMC_OFS_PIN08 32'h50020678
`define PMC_OFS_PIN09 32'h5002067c
`define PMC_OFS_PIN10 32'h50020680
`define PMC_OFS_PIN11 32'h50020684
`define PMC_OFS_PIN12 32'h50020688

// ****************************************
// Field positions and reset values
// ****************************************
`define PMC_DRIVE_BIT 10
`define PMC_DIRPULL_HI 9
`define PMC_DIRPULL_LO 8
`define PMC_FUNC_HI 5
`define PMC_FUNC_LO 0
`define PMC_DIRPULL_RST 2'h2
`define PMC_DRIVE_RST 1'h0
`define PMC_FUNC_RST 6'h00
`define PMC_CODE_NOPULL 2'h0
`define PMC_CODE_PULLUP 2'h1
`define PMC_CODE_PULLDN 2'h2
`define PMC_CODE_OUTPUT 2'h3

`endif

// ### hw/pmc_pkg.sv
// Types of the pad mode configuration block.
// Assumes pmc_params.svh is in the include path.
package pmc_pkg;
    // One pin's stored configuration
    typedef struct packed {
        logic driveTypeSelect;
        logic [1:0] directionPullSelect;
        logic [5:0] functionSelect;
    } pmc_cfg_s;

    // Pad controls handed to one pad cell
    typedef struct packed {
        logic outputEnable;
        logic openDrain;
        logic pullUpEn;
        logic pullDownEn;
        logic [5:0] functionSelect;
    } pmc_pad_s;
endpackage

// ### verif/pmc_pad_model.sv
// Behavioural model of one I/O pad cell behind the pad controls.
// Assumes the pad takes its control levels straight from padCtrl.
`timescale 1ns/1ns
module pmc_pad_model (
    // Clock
    input wire logic sys_clk,
    // Pad controls in
    input wire pmc_pkg::pmc_pad_s pad,
    // Resolved pin level
    output logic level
);
    import pmc_pkg::*;
    logic floatLevel = 1'b0;
    // Unpulled, undriven pin wanders; toggle so no stale level can pass
    always @(posedge sys_clk) begin
        floatLevel <= ~floatLevel;
    end
    // Push-pull drives the data high; open drain only releases it
    always_comb begin
        if (pad.outputEnable && !pad.openDrain) begin
            level = 1'b1;
        end else if (pad.pullUpEn) begin
            level = 1'b1;
        end else if (pad.pullDownEn) begin
            level = 1'b0;
        end else begin
            level = floatLevel;
        end
    end
endmodule

// ### verif/test_pmc_pad_mode_config.sv
// Self-checking bench of the pad mode configuration block over APB.
// Assumes the zero wait state answer and one cycle pad latency.
`timescale 1ns/1ns
`include "pmc_params.svh"
module test_pmc_pad_mode_config;
    import pmc_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, clkEn = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic [4:0] analogMode = 5'h00;
    logic [4:0] pinLevel;
    pmc_pad_s [4:0] padCtrl;
    int fails = 0, checksDone = 0;
    // ****************************************
    // Design and pads
    // ****************************************
    pmc_pad_mode_config dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .analogMode(analogMode), .padCtrl(padCtrl));
    for (genvar g = 0; g < 5; g++) begin : gPad
        pmc_pad_model pad (.sys_clk(sys_clk), .pad(padCtrl[g]),
            .level(pinLevel[g]));
    end
    always #2 sys_clk = ~sys_clk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (n < 20) begin
            rd = prdata;
            err = pslverr;
            // Let an edge pass so the next call never reassigns psel in
            // the same time step
            @(posedge sys_clk);
        end else begin
            fails++;
            final_report();
        end
    endtask
    function automatic logic [31:0] padExp(input logic [1:0] c,
                                           input logic od);
        return {22'h0, c == 2'h3, (c == 2'h3) & od, c == 2'h1, c == 2'h2,
                6'h3f};
    endfunction
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        // Every register and pad out of reset
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, `PMC_OFS_PIN08 + 32'(4 * i), 32'h0);
            chk(rd, 32'h200);
            chk({22'h0, padCtrl[i]}, 32'h040);
            chk({31'h0, err}, 32'h0);
        end
        // All four direction codes, open drain, all ones elsewhere
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `PMC_OFS_PIN08, {21'h1fffff, 1'b1, 2'(c), 8'hff});
            apb(1'b0, `PMC_OFS_PIN08, 32'h0);
            chk(rd, {21'h0, 1'b1, 2'(c), 8'h3f});
            repeat (2) @(posedge sys_clk);
            chk({22'h0, padCtrl[0]}, padExp(2'(c), 1'b1));
            if (c == 1 || c == 2) begin
                chk({31'h0, pinLevel[0]}, {31'h0, c == 1});
            end
        end
        // Output in push-pull drives the pin
        apb(1'b1, `PMC_OFS_PIN08, 32'h33f);
        repeat (2) @(posedge sys_clk);
        chk({22'h0, padCtrl[0]}, padExp(2'h3, 1'b0));
        chk({31'h0, pinLevel[0]}, 32'h1);
        // Pull-up on a second pin
        apb(1'b1, `PMC_OFS_PIN10, 32'h13f);
        apb(1'b0, `PMC_OFS_PIN10, 32'h0);
        chk(rd, 32'h13f);
        repeat (2) @(posedge sys_clk);
        chk({22'h0, padCtrl[2]}, padExp(2'h1, 1'b0));
        chk({31'h0, pinLevel[2]}, 32'h1);
        // Clock enable low freezes the pads; then analog mode hides the
        // direction field of its own pins only
        clkEn <= 1'b0;
        analogMode <= 5'h11;
        repeat (2) @(posedge sys_clk);
        chk({22'h0, padCtrl[0]}, padExp(2'h3, 1'b0));
        clkEn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({22'h0, padCtrl[0]}, 32'h03f);
        chk({22'h0, padCtrl[1]}, 32'h040);
        chk({22'h0, padCtrl[4]}, 32'h000);
        // Unmapped address is refused and stores nothing
        apb(1'b1, 32'h5002068c, 32'h7ff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 32'h5002068c, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `PMC_OFS_PIN12, 32'h0);
        chk(rd, 32'h200);
        // Reset in mid-run brings an output pin back to pulled-down input
        rst <= 1'b1;
        analogMode <= 5'h00;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, `PMC_OFS_PIN08, 32'h0);
        chk(rd, 32'h200);
        chk({22'h0, padCtrl[0]}, 32'h040);
        chk({31'h0, err}, 32'h0);
        final_report();
    end
endmodule
